//--- shared/pci_pkg.sv
// Constants and carrier types of the pin change interrupt block.
// Assumes one core clock and a plain register port with one-cycle read latency.
`default_nettype none
package pci_pkg;
  localparam int unsigned PORT_W = 8;
  localparam int unsigned ADDR_W = 4;
  localparam logic [ADDR_W-1:0] ADDR_PORT_A_DATA = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_PORT_B_DATA = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_PORT_A_ENABLE = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_PORT_B_ENABLE = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_INTERRUPT_CONTROL = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 4'h5;
  localparam logic [PORT_W-1:0] ENABLE_RESET = 8'h00;
  localparam logic [PORT_W-1:0] PORT_B_IMPL_MASK = 8'hf7;
  localparam logic [PORT_W-1:0] PORT_A_PIN5_MASK = 8'h20;
  localparam logic [PORT_W-1:0] CTRL_IMPL_MASK = 8'h09;
  localparam logic [PORT_W-1:0] MASK_RESET = 8'h01;
  localparam int unsigned FLAG_BIT = 0;
  localparam int unsigned IRQ_EN_BIT = 3;
  localparam int unsigned SYNC_STAGES = 2;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [PORT_W-1:0] wdata;
    logic wr;
    logic rd;
  } pci_req_s;
endpackage : pci_pkg
`default_nettype wire

//--- src/pci_sync.sv
// Two-stage synchroniser for a vector of pin levels.
// Assumes the inputs are asynchronous to i_clock.
`default_nettype none
module pci_sync #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] stage1_ff;
  logic [WIDTH-1:0] stage2_ff;

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      stage1_ff <= '0;
      stage2_ff <= '0;
    end else begin
      stage1_ff <= i_async;
      stage2_ff <= stage1_ff;
    end
  end

  assign o_sync = stage2_ff;
endmodule : pci_sync
`default_nettype wire

//--- src/pci_top.sv
// Pin change detection for two eight-pin ports (port B pin 3 cannot be armed) with a shared sticky flag.
// Assumes pins are asynchronous and software uses the plain register port.
`default_nettype none

module pci_top (
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic i_master_clear,
  input wire logic i_master_clear_input_pin_mode,
  input wire logic [pci_pkg::PORT_W-1:0] i_port_a_pins,
  input wire logic [pci_pkg::PORT_W-1:0] i_port_b_pins,
  input wire logic [pci_pkg::ADDR_W-1:0] i_addr,
  input wire logic [pci_pkg::PORT_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [pci_pkg::PORT_W-1:0] o_rdata,
  output logic o_irq,
  output logic o_wake
);
  import pci_pkg::*;

  pci_req_s req;
  logic [PORT_W-1:0] pa_sync;
  logic [PORT_W-1:0] pb_sync;
  logic [PORT_W-1:0] port_a_change_enable_ff;
  logic [PORT_W-1:0] port_b_change_enable_ff;
  logic [PORT_W-1:0] last_a_ff;
  logic [PORT_W-1:0] last_b_ff;
  logic [PORT_W-1:0] irq_mask_ff;
  logic pin_change_flag_ff;
  logic pin_change_irq_enable_ff;
  logic [PORT_W-1:0] rdata_ff;
  logic [PORT_W-1:0] arm_a;
  logic [PORT_W-1:0] arm_b;
  logic port_access;
  logic mismatch;
  logic nxt_flag;
  logic [PORT_W-1:0] ctrl_view;
  logic [PORT_W-1:0] status_view;
  logic any_reset;

  assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};
  assign any_reset = i_srst | i_master_clear;

  pci_sync #(.WIDTH(PORT_W)) u_sync_a (
    .i_clock(i_clock),
    .i_srst(i_srst),
    .i_async(i_port_a_pins),
    .o_sync(pa_sync)
  );

  pci_sync #(.WIDTH(PORT_W)) u_sync_b (
    .i_clock(i_clock),
    .i_srst(i_srst),
    .i_async(i_port_b_pins),
    .o_sync(pb_sync)
  );

  // Enables are cleared by power-on reset and by master clear.
  always_ff @(posedge i_clock) begin
    if (any_reset) begin
      port_a_change_enable_ff <= ENABLE_RESET;
      port_b_change_enable_ff <= ENABLE_RESET;
    end else if (req.wr) begin
      if (req.addr == ADDR_PORT_A_ENABLE) begin
        port_a_change_enable_ff <= req.wdata;
      end
      if (req.addr == ADDR_PORT_B_ENABLE) begin
        port_b_change_enable_ff <= req.wdata & PORT_B_IMPL_MASK;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (any_reset) begin
      irq_mask_ff <= MASK_RESET;
    end else if (req.wr && req.addr == ADDR_IRQ_MASK) begin
      irq_mask_ff <= req.wdata & CTRL_IMPL_MASK & MASK_RESET;
    end
  end

  assign arm_a = port_a_change_enable_ff & ~(i_master_clear_input_pin_mode ? PORT_A_PIN5_MASK : ENABLE_RESET);
  assign arm_b = port_b_change_enable_ff & PORT_B_IMPL_MASK;

  // The stored copy sees power-on reset only, so master clear keeps it.
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      last_a_ff <= '0;
      last_b_ff <= '0;
    end else begin
      if ((req.rd || req.wr) && req.addr == ADDR_PORT_A_DATA) begin
        last_a_ff <= pa_sync;
      end
      if ((req.rd || req.wr) && req.addr == ADDR_PORT_B_DATA) begin
        last_b_ff <= pb_sync;
      end
    end
  end

  assign port_access = (req.rd || req.wr) &&
                       (req.addr == ADDR_PORT_A_DATA || req.addr == ADDR_PORT_B_DATA);
  // A mismatch on either port is dropped during a data access to either port, though only the accessed port's copy is reloaded.
  assign mismatch = !port_access &&
                    (|((pa_sync ^ last_a_ff) & arm_a) || |((pb_sync ^ last_b_ff) & arm_b));

  always_comb begin
    nxt_flag = pin_change_flag_ff;
    if (req.wr && req.addr == ADDR_INTERRUPT_CONTROL && req.wdata[FLAG_BIT]) begin
      nxt_flag = 1'b0;
    end
    if (mismatch) begin
      nxt_flag = 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (any_reset) begin
      pin_change_flag_ff <= 1'b0;
    end else begin
      pin_change_flag_ff <= nxt_flag;
    end
  end

  always_ff @(posedge i_clock) begin
    if (any_reset) begin
      pin_change_irq_enable_ff <= 1'b0;
    end else if (req.wr && req.addr == ADDR_INTERRUPT_CONTROL) begin
      pin_change_irq_enable_ff <= req.wdata[IRQ_EN_BIT];
    end
  end

  assign ctrl_view = {4'h0, pin_change_irq_enable_ff, 2'h0, pin_change_flag_ff};
  assign status_view = {7'h00, pin_change_flag_ff};

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      rdata_ff <= '0;
    end else if (req.rd) begin
      case (req.addr)
        ADDR_PORT_A_DATA: rdata_ff <= pa_sync;
        ADDR_PORT_B_DATA: rdata_ff <= pb_sync;
        ADDR_PORT_A_ENABLE: rdata_ff <= port_a_change_enable_ff;
        ADDR_PORT_B_ENABLE: rdata_ff <= port_b_change_enable_ff & PORT_B_IMPL_MASK;
        ADDR_INTERRUPT_CONTROL: rdata_ff <= ctrl_view;
        ADDR_IRQ_MASK: rdata_ff <= irq_mask_ff;
        default: rdata_ff <= '0;
      endcase
    end else begin
      rdata_ff <= '0;
    end
  end

  assign o_rdata = rdata_ff;
  assign o_irq = pin_change_irq_enable_ff && |(status_view & irq_mask_ff);
  assign o_wake = pin_change_irq_enable_ff && pin_change_flag_ff;

  armed_sets_flag_a: assert property (@(posedge i_clock) disable iff (any_reset)
    mismatch |=> pin_change_flag_ff) else $error("mismatch did not set flag");
  clear_wins_not_a: assert property (@(posedge i_clock) disable iff (any_reset)
    (mismatch && req.wr && req.addr == ADDR_INTERRUPT_CONTROL) |=> pin_change_flag_ff)
    else $error("clear beat a live mismatch");
  pin5_forced_off_a: assert property (@(posedge i_clock) disable iff (any_reset)
    i_master_clear_input_pin_mode |-> !arm_a[5]) else $error("pin 5 armed as master clear");
  b_bit3_zero_a: assert property (@(posedge i_clock) disable iff (any_reset)
    !port_b_change_enable_ff[3]) else $error("port b bit 3 set");
  copy_loads_read_a: assert property (@(posedge i_clock) disable iff (any_reset)
    (req.rd && req.addr == ADDR_PORT_A_DATA) |=> last_a_ff == o_rdata)
    else $error("copy differs from read data");
  gate_only_irq_a: assert property (@(posedge i_clock) disable iff (any_reset)
    !pin_change_irq_enable_ff |-> !o_irq) else $error("irq without enable");
  wake_on_change_a: assert property (@(posedge i_clock) disable iff (any_reset)
    (mismatch && pin_change_irq_enable_ff && !(req.wr && req.addr == ADDR_INTERRUPT_CONTROL))
    |=> o_wake) else $error("no wake on change");
  sync_latency_a: assert property (@(posedge i_clock) disable iff (any_reset)
    $changed(i_port_a_pins) && !$changed(pa_sync) |-> ##2 pa_sync == $past(i_port_a_pins, 2))
    else $error("sync latency wrong");
  enable_reset_a: assert property (@(posedge i_clock)
    i_srst |=> port_a_change_enable_ff == ENABLE_RESET) else $error("enable not cleared");
  // Master clear must leave the stored copies alone so a standing mismatch flags again.
  copy_kept_master_clear_input_a: assert property (@(posedge i_clock) disable iff (i_srst)
    (i_master_clear && !port_access) |=> ($stable(last_a_ff) && $stable(last_b_ff)))
    else $error("stored copy lost on master clear");
  rdata_idle_zero_a: assert property (@(posedge i_clock) disable iff (any_reset)
    !req.rd |=> o_rdata == '0) else $error("read data without a read");

  flag_set_c: cover property (@(posedge i_clock) disable iff (any_reset) $rose(pin_change_flag_ff));
  irq_c: cover property (@(posedge i_clock) disable iff (any_reset) $rose(o_irq));
  clear_c: cover property (@(posedge i_clock) disable iff (any_reset) $fell(pin_change_flag_ff));
  wake_c: cover property (@(posedge i_clock) disable iff (any_reset) $rose(o_wake));
endmodule : pci_top
`default_nettype wire

//--- verification/pci_pin_drv.sv
// Model of the outside circuitry that drives both port pin groups.
// Assumes the bench requests new levels; they reach the pins at the next clock edge.
`default_nettype none
module pci_pin_drv (
  input wire logic i_clock,
  input wire logic [15:0] i_lvl,
  output logic [7:0] o_port_a,
  output logic [7:0] o_port_b
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge i_clock) begin
    {o_port_a, o_port_b} <= i_lvl;
  end
endmodule : pci_pin_drv
`default_nettype wire

//--- verification/pci_top_tb_top.sv
// Self-checking bench of the pin change interrupt block.
// Assumes the pin driver model and the register map of the package.
`default_nettype none
module pci_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pci_pkg::*;
  logic i_clock, i_srst, i_master_clear, i_master_clear_input_pin_mode, i_wr, i_rd, o_irq, o_wake;
  logic [ADDR_W-1:0] i_addr;
  logic [PORT_W-1:0] i_wdata, o_rdata, pa, pb;
  logic [15:0] lvl;
  int miscompares, n_tests, cyc;
  logic [19:0] rows [6] = '{{ADDR_PORT_A_ENABLE, 8'hff, 8'hff}, {ADDR_PORT_B_ENABLE, 8'hff, 8'hf7},
    {ADDR_IRQ_MASK, 8'hff, 8'h01}, {4'hf, 8'hff, 8'h00},
    {ADDR_PORT_A_ENABLE, 8'h00, 8'h00}, {ADDR_PORT_B_ENABLE, 8'h00, 8'h00}};

  pci_pin_drv u_pins (.i_clock(i_clock), .i_lvl(lvl), .o_port_a(pa), .o_port_b(pb));
  pci_top DUT (.i_clock(i_clock), .i_srst(i_srst), .i_master_clear(i_master_clear),
    .i_master_clear_input_pin_mode(i_master_clear_input_pin_mode), .i_port_a_pins(pa), .i_port_b_pins(pb),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_irq(o_irq), .o_wake(o_wake));

  initial begin
    i_clock = 1'b0;
    forever #12.5 i_clock = ~i_clock;
  end

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done

  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 2000) begin
      miscompares++;
      test_done();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge i_clock);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1 chk(o_rdata, exp);
  endtask : rd

  // Sets new pin levels and waits past the synchroniser and flag latency.
  task automatic pins(input logic [15:0] v);
    @(posedge i_clock);
    lvl <= v;
    repeat (5) @(posedge i_clock);
  endtask : pins

  initial begin
    {i_srst, i_master_clear, i_master_clear_input_pin_mode, i_wr, i_rd} = 5'h10;
    {i_addr, i_wdata, lvl} = '0;
    repeat (12) @(posedge i_clock);
    i_srst <= 1'b0;
    rd(ADDR_PORT_A_ENABLE, ENABLE_RESET);
    rd(ADDR_PORT_B_ENABLE, ENABLE_RESET);
    rd(ADDR_IRQ_MASK, MASK_RESET);
    rd(ADDR_INTERRUPT_CONTROL, 8'h00);
    foreach (rows[i]) begin
      wr(rows[i][19:16], rows[i][15:8]);
      rd(rows[i][19:16], rows[i][7:0]);
    end
    $display("register test done");
    pins(16'h0100);
    rd(ADDR_INTERRUPT_CONTROL, 8'h00);
    wr(ADDR_PORT_A_ENABLE, 8'h01);
    rd(ADDR_PORT_A_DATA, 8'h01);
    pins(16'h0000);
    rd(ADDR_INTERRUPT_CONTROL, 8'h01);
    chk({6'h00, o_irq, o_wake}, 8'h00);
    wr(ADDR_INTERRUPT_CONTROL, 8'h08);
    #1 chk({6'h00, o_irq, o_wake}, 8'h03);
    wr(ADDR_INTERRUPT_CONTROL, 8'h09);
    rd(ADDR_INTERRUPT_CONTROL, 8'h09);
    wr(ADDR_IRQ_MASK, 8'h00);
    #1 chk({6'h00, o_irq, o_wake}, 8'h01);
    wr(ADDR_IRQ_MASK, 8'h01);
    rd(ADDR_PORT_A_DATA, 8'h00);
    wr(ADDR_INTERRUPT_CONTROL, 8'h09);
    rd(ADDR_INTERRUPT_CONTROL, 8'h08);
    #1 chk({6'h00, o_irq, o_wake}, 8'h00);
    $display("port a change test done");
    wr(ADDR_PORT_B_ENABLE, 8'h08);
    pins(16'h0008);
    rd(ADDR_INTERRUPT_CONTROL, 8'h08);
    wr(ADDR_PORT_B_ENABLE, 8'h04);
    pins(16'h000c);
    rd(ADDR_INTERRUPT_CONTROL, 8'h09);
    wr(ADDR_PORT_B_DATA, 8'h00);
    wr(ADDR_INTERRUPT_CONTROL, 8'h09);
    rd(ADDR_INTERRUPT_CONTROL, 8'h08);
    pins(16'h0000);
    @(posedge i_clock);
    i_master_clear <= 1'b1;
    @(posedge i_clock);
    i_master_clear <= 1'b0;
    rd(ADDR_PORT_B_ENABLE, 8'h00);
    wr(ADDR_PORT_B_ENABLE, 8'h04);
    rd(ADDR_INTERRUPT_CONTROL, 8'h01);
    rd(ADDR_PORT_B_DATA, 8'h00);
    wr(ADDR_INTERRUPT_CONTROL, 8'h01);
    rd(ADDR_INTERRUPT_CONTROL, 8'h00);
    $display("port b and master clear test done");
    i_master_clear_input_pin_mode <= 1'b1;
    wr(ADDR_PORT_A_ENABLE, 8'h20);
    rd(ADDR_PORT_A_DATA, 8'h00);
    pins(16'h2000);
    rd(ADDR_INTERRUPT_CONTROL, 8'h00);
    i_master_clear_input_pin_mode <= 1'b0;
    pins(16'h2000);
    rd(ADDR_INTERRUPT_CONTROL, 8'h01);
    $display("master clear pin test done");
    test_done();
  end
endmodule : pci_top_tb_top
`default_nettype wire
